// file: gtd_defs.svh
// Register offsets, field positions and constants of the tone detector.
`ifndef GTD_DEFS_SVH
`define GTD_DEFS_SVH
`define GTD_ADDR_CFG 8'h1C
`define GTD_ADDR_LEN 8'h1D
`define GTD_ADDR_STAT 8'h1E
`define GTD_CFG_EN 0
`define GTD_CFG_HARM 1
`define GTD_CFG_SRC 2
`define GTD_CFG_STOP 3
`define GTD_CFG_CHBL 4
`define GTD_CFG_RESTART 6
`define GTD_CFG_ULAW 7
`define GTD_CFG_WMASK 8'h9F
`define GTD_CFG_RST 8'h00
`define GTD_LEN_RST 8'h00
`define GTD_RD_NONE 8'h00
`define GTD_BASE_SMALL 16'h1000
`define GTD_BASE_LARGE 16'h2000
`define GTD_WIN_BYTES 16'h0400
`define GTD_K_FRAC 14
`define GTD_X_SHIFT 3
`define GTD_FREQ_FIRST 4'h0
`define GTD_FREQ_LAST_FUND 4'h7
`define GTD_FREQ_LAST_HARM 4'hF
`define GTD_K_TABLE {16'h94B0, 16'hA8D2, 16'hBF89, 16'hD6BB, 16'h0BD8, 16'h1D7D, 16'h2BD5, \
	16'h3993, 16'h2463, 16'h331D, 16'h3FC5, 16'h4A81, 16'h5E9B, 16'h6465, 16'h694C, 16'h6D4C}
`define GTD_ULAW_BIAS 16'h0084
`define GTD_ALAW_XOR 8'h55
`define GTD_ALAW_RND 16'h0008
`define GTD_ALAW_SEG 16'h0108
`define GTD_CLK_MHZ 20
`define GTD_SAMPLE_US 125
`define GTD_SAMPLE_CYC (`GTD_SAMPLE_US * `GTD_CLK_MHZ)
`endif

// file: gtd_pkg.sv
// Types shared by the tone detector modules.
package gtd_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} gtd_state_t;
	typedef logic signed [15:0] gtd_word_t;
endpackage : gtd_pkg

// file: gtd_mem_if.sv
// Port bundle between the filter engine and the coefficient memory.
`timescale 1ns/10ps
`default_nettype none
interface gtd_mem_if #(parameter int AW = 8, parameter int DW = 32);
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] host_addr;
	logic [DW-1:0] host_data;
	modport eng (output rd_addr, wr_en, wr_addr, wr_data, host_addr, input rd_data, host_data);
	modport mem (input rd_addr, wr_en, wr_addr, wr_data, host_addr, output rd_data, host_data);
endinterface : gtd_mem_if
`default_nettype wire

// file: gtd_coef_ram.sv
// Coefficient memory with one write port and two registered read ports.
`timescale 1ns/10ps
`default_nettype none
module gtd_coef_ram #(
	parameter int AW = 8,
	parameter int DW = 32
) (
	input wire logic clk,
	gtd_mem_if.mem bus
);
	logic [DW-1:0] mem_q [2**AW];

	always_ff @(posedge clk)
	begin
		if (bus.wr_en)
		begin
			mem_q[bus.wr_addr] <= bus.wr_data;
		end
	end

	always_ff @(posedge clk)
	begin
		bus.rd_data <= mem_q[bus.rd_addr];
	end

	always_ff @(posedge clk)
	begin
		bus.host_data <= mem_q[bus.host_addr];
	end
endmodule : gtd_coef_ram
`default_nettype wire

// file: gtd_g711_expand.sv
// Companded sample to signed linear expander with registered output.
`timescale 1ns/10ps
`default_nettype none
`include "gtd_defs.svh"
module gtd_g711_expand (
	input wire logic clk,
	input wire logic [7:0] code,
	input wire logic ulaw,
	output logic signed [15:0] lin
);
	function automatic logic signed [15:0] gtd_mu(input logic [7:0] c);
		logic [7:0] u;
		logic [15:0] m;
		u = ~c;
		m = ((16'({u[3:0], 3'h0}) + `GTD_ULAW_BIAS) << u[6:4]) - `GTD_ULAW_BIAS;
		return u[7] ? -$signed(m) : $signed(m);
	endfunction : gtd_mu

	function automatic logic signed [15:0] gtd_al(input logic [7:0] c);
		logic [7:0] a;
		logic [15:0] m;
		a = c ^ `GTD_ALAW_XOR;
		if (a[6:4] == 3'h0)
			m = 16'({a[3:0], 4'h0}) + `GTD_ALAW_RND;
		else
			m = (16'({a[3:0], 4'h0}) + `GTD_ALAW_SEG) << (a[6:4] - 3'h1);
		return a[7] ? $signed(m) : -$signed(m);
	endfunction : gtd_al

	always_ff @(posedge clk)
	begin
		lin <= ulaw ? gtd_mu(code) : gtd_al(code);
	end
endmodule : gtd_g711_expand
`default_nettype wire

// file: gtd_tone_detector.sv
// Multi-channel Goertzel tone detection engine with register port and coefficient memory.
// Notes on behaviour
// - New state is K times state minus older state plus sample.
// - Update runs once per sample, every 125 us.
// - Both previous states are zero at block start.
// - K is twice cosine, scaled by two to fourteen.
// - Fixed signed 16-bit K per tone from table.
// - Low harmonic bins use shifted 1406 and 1555 Hz.
// - Engine idles until enable bit set.
// - Iterations per block come from sample-count field.
// - Continuous mode restarts block right after completion.
// - Stop mode halts after block and raises flag.
// - Samples arriving while halted are not taken; pcm_ready stays low.
// - Final two 16-bit states stored in memory.
// - Memory address is base plus frequency, channel, byte.
// - 32 channels use 8 tones, 16 channels 16.
// - Harmonic select chooses 8x32 or 16x16 operation.
// - Source select picks transmit or receive samples.
// - Block holds sample count plus one samples.
// - Restart bit starts new block, clears itself.
`timescale 1ns/10ps
`default_nettype none
`include "gtd_defs.svh"
module gtd_tone_detector #(
	parameter bit LARGE_RAM = 1'b0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic pcm_valid,
	input wire logic pcm_dir,
	input wire logic [4:0] pcm_chan,
	input wire logic [7:0] pcm_code,
	input wire logic pcm_frame,
	output logic pcm_ready,
	input wire logic [15:0] host_addr,
	input wire logic host_rd,
	output logic [7:0] host_rdata,
	output logic host_rvalid,
	output logic tone_block_done_flag
);
	logic [7:0] cfg_reg;
	logic [7:0] len_reg;
	logic restart_reg;
	logic started_reg;
	logic halted_reg;
	logic stop_pend_reg;
	logic done_reg;
	logic [7:0] idx_reg;
	gtd_pkg::gtd_state_t state_reg;
	logic [3:0] freq_reg;
	logic [4:0] ch_reg;
	logic first_s_reg;
	logic harm_s_reg;
	gtd_pkg::gtd_word_t x_reg;
	gtd_pkg::gtd_word_t lin;
	gtd_pkg::gtd_word_t wn;
	gtd_pkg::gtd_word_t wn1;
	gtd_pkg::gtd_word_t w_next;
	logic [15:0] host_off;
	logic [1:0] hsel_reg;
	logic hwin_reg;
	logic hrd_reg;
	logic [11:0] busy_cnt;
	logic tone_engine_enable;
	logic harmonic_select;
	logic tone_source_select;
	logic stop_after_block;
	logic running;
	logic accept;
	logic halt_now;
	logic stat_rd;
	logic [3:0] freq_last;

	gtd_mem_if #(.AW(8), .DW(32)) mem_bus ();

	// Index layout mirrors the byte map: tone, harmonic or upper channel bit, channel.
	function automatic logic [7:0] gtd_index(input logic [3:0] f, input logic [4:0] c,
		input logic h);
		return {f[2:0], (h ? f[3] : c[4]), c[3:0]};
	endfunction : gtd_index

	function automatic gtd_pkg::gtd_word_t gtd_k(input logic [3:0] f);
		logic [255:0] tab;
		tab = `GTD_K_TABLE;
		return tab[{f, 4'h0} +: 16];
	endfunction : gtd_k

	// Wraps at 16 bits; a long block on a loud tone overflows by design.
	function automatic gtd_pkg::gtd_word_t gtd_step(input gtd_pkg::gtd_word_t k,
		input gtd_pkg::gtd_word_t a, input gtd_pkg::gtd_word_t b, input gtd_pkg::gtd_word_t x);
		logic signed [31:0] p;
		p = k * a;
		return 16'(p >>> `GTD_K_FRAC) - b + x;
	endfunction : gtd_step

	function automatic logic [7:0] gtd_byte(input logic [31:0] w, input logic [1:0] s);
		logic [7:0] r;
		r = `GTD_RD_NONE;
		unique case (s)
			2'h0: r = w[23:16];
			2'h1: r = w[31:24];
			2'h2: r = w[7:0];
			2'h3: r = w[15:8];
		endcase
		return r;
	endfunction : gtd_byte

	assign tone_engine_enable = cfg_reg[`GTD_CFG_EN];
	assign harmonic_select = cfg_reg[`GTD_CFG_HARM];
	assign tone_source_select = cfg_reg[`GTD_CFG_SRC];
	assign stop_after_block = cfg_reg[`GTD_CFG_STOP];
	assign tone_block_done_flag = done_reg;
	assign stat_rd = reg_rd && (reg_addr == `GTD_ADDR_STAT);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cfg_reg <= `GTD_CFG_RST;
			len_reg <= `GTD_LEN_RST;
		end
		else if (reg_wr && (reg_addr == `GTD_ADDR_CFG))
			cfg_reg <= reg_wdata & `GTD_CFG_WMASK;
		else if (reg_wr && (reg_addr == `GTD_ADDR_LEN))
			len_reg <= reg_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			restart_reg <= 1'b0;
		else
			restart_reg <= reg_wr && (reg_addr == `GTD_ADDR_CFG) && reg_wdata[`GTD_CFG_RESTART];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			reg_rdata <= `GTD_RD_NONE;
		else if (stat_rd)
			reg_rdata <= {4'h0, (state_reg != gtd_pkg::ST_IDLE), running, halted_reg, done_reg};
		else
			reg_rdata <= `GTD_RD_NONE;
	end

	assign running = tone_engine_enable && started_reg && !halted_reg && !stop_pend_reg;
	assign halt_now = tone_engine_enable && !restart_reg && stop_pend_reg
		&& (state_reg == gtd_pkg::ST_IDLE);

	// The block counter advances on the frame pulse, so a block spans whole sample periods.
	always_ff @(posedge clk)
	begin
		if (srst || !tone_engine_enable)
		begin
			started_reg <= 1'b0;
			halted_reg <= 1'b0;
			stop_pend_reg <= 1'b0;
			idx_reg <= 8'h00;
		end
		else if (restart_reg)
		begin
			started_reg <= 1'b0;
			halted_reg <= 1'b0;
			stop_pend_reg <= 1'b0;
			idx_reg <= 8'h00;
		end
		else if (pcm_frame && !halted_reg && !stop_pend_reg)
		begin
			if (!started_reg)
			begin
				started_reg <= 1'b1;
				idx_reg <= 8'h00;
			end
			else if (idx_reg == len_reg)
			begin
				idx_reg <= 8'h00;
				stop_pend_reg <= stop_after_block;
			end
			else
				idx_reg <= idx_reg + 8'h01;
		end
		else if (halt_now)
		begin
			stop_pend_reg <= 1'b0;
			halted_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			done_reg <= 1'b0;
		else if (halt_now)
			done_reg <= 1'b1;
		else if (stat_rd)
			done_reg <= 1'b0;
	end

	// Unwanted samples are taken and dropped whenever pcm_ready is high; like any sample they stall the source while a pass runs or the engine is not running.
	assign pcm_ready = running && (state_reg == gtd_pkg::ST_IDLE);
	assign accept = pcm_valid && pcm_ready && (pcm_dir == tone_source_select)
		&& (!harmonic_select || (pcm_chan[4] == cfg_reg[`GTD_CFG_CHBL]));

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ch_reg <= 5'h00;
			first_s_reg <= 1'b0;
			harm_s_reg <= 1'b0;
		end
		else if (accept)
		begin
			ch_reg <= pcm_chan;
			first_s_reg <= (idx_reg == 8'h00);
			harm_s_reg <= harmonic_select;
		end
	end

	gtd_g711_expand u_expand (
		.clk(clk),
		.code(pcm_code),
		.ulaw(cfg_reg[`GTD_CFG_ULAW]),
		.lin(lin)
	);

	always_ff @(posedge clk)
	begin
		if (srst)
			x_reg <= 16'sh0000;
		else if ((state_reg == gtd_pkg::ST_RD) && (freq_reg == `GTD_FREQ_FIRST))
			x_reg <= lin >>> `GTD_X_SHIFT;
	end

	assign freq_last = harm_s_reg ? `GTD_FREQ_LAST_HARM : `GTD_FREQ_LAST_FUND;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_reg <= gtd_pkg::ST_IDLE;
			freq_reg <= `GTD_FREQ_FIRST;
		end
		else
		begin
			unique case (state_reg)
				gtd_pkg::ST_IDLE:
					if (accept)
					begin
						state_reg <= gtd_pkg::ST_RD;
						freq_reg <= `GTD_FREQ_FIRST;
					end
				gtd_pkg::ST_RD:
					state_reg <= gtd_pkg::ST_WR;
				gtd_pkg::ST_WR:
					if (freq_reg == freq_last)
						state_reg <= gtd_pkg::ST_IDLE;
					else
					begin
						freq_reg <= freq_reg + 4'h1;
						state_reg <= gtd_pkg::ST_RD;
					end
			endcase
		end
	end

	// The first sample of a block ignores stored states, which clears them without a sweep.
	assign wn = first_s_reg ? 16'sh0000 : mem_bus.rd_data[31:16];
	assign wn1 = first_s_reg ? 16'sh0000 : mem_bus.rd_data[15:0];
	assign w_next = gtd_step(gtd_k(freq_reg), wn, wn1, x_reg);

	assign mem_bus.rd_addr = gtd_index(freq_reg, ch_reg, harm_s_reg);
	assign mem_bus.wr_addr = gtd_index(freq_reg, ch_reg, harm_s_reg);
	assign mem_bus.wr_en = (state_reg == gtd_pkg::ST_WR);
	assign mem_bus.wr_data = {w_next, wn};

	gtd_coef_ram #(.AW(8), .DW(32)) u_ram (
		.clk(clk),
		.bus(mem_bus)
	);

	assign host_off = host_addr - (LARGE_RAM ? `GTD_BASE_LARGE : `GTD_BASE_SMALL);
	assign mem_bus.host_addr = host_off[9:2];

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			hrd_reg <= 1'b0;
			hwin_reg <= 1'b0;
			hsel_reg <= 2'h0;
		end
		else
		begin
			hrd_reg <= host_rd;
			hwin_reg <= host_off < `GTD_WIN_BYTES;
			hsel_reg <= host_off[1:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			host_rvalid <= 1'b0;
			host_rdata <= `GTD_RD_NONE;
		end
		else
		begin
			host_rvalid <= hrd_reg;
			host_rdata <= (hrd_reg && hwin_reg) ? gtd_byte(mem_bus.host_data, hsel_reg)
				: `GTD_RD_NONE;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst || (state_reg == gtd_pkg::ST_IDLE))
			busy_cnt <= 12'h000;
		else
			busy_cnt <= busy_cnt + 12'h001;
	end

	property p_off_idle;
		@(posedge clk) disable iff (srst) !tone_engine_enable |-> !pcm_ready;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("Engine ready while disabled.");

	property p_halt_drop;
		@(posedge clk) disable iff (srst) halted_reg |-> !pcm_ready && !accept;
	endproperty
	a_halt_drop: assert property (p_halt_drop) else $error("Sample taken while halted.");

	property p_stop_halt;
		@(posedge clk) disable iff (srst) halt_now |=> halted_reg && done_reg && !pcm_ready;
	endproperty
	a_stop_halt: assert property (p_stop_halt) else $error("Stop did not halt and flag.");

	property p_restart;
		@(posedge clk) disable iff (srst)
			reg_wr && (reg_addr == `GTD_ADDR_CFG) && reg_wdata[`GTD_CFG_RESTART]
			&& reg_wdata[`GTD_CFG_EN] && halted_reg |=> ##1 !halted_reg && !started_reg;
	endproperty
	a_restart: assert property (p_restart) else $error("Restart did not release halt.");

	property p_wrap;
		@(posedge clk) disable iff (srst)
			running && !restart_reg && pcm_frame && (idx_reg == len_reg) && !stop_after_block
			|=> (idx_reg == 8'h00) && !halted_reg;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Block did not wrap after count plus one.");

	property p_fund_len;
		@(posedge clk) disable iff (srst)
			accept && !harmonic_select |=> (state_reg != gtd_pkg::ST_IDLE) [*8] ##9
			(state_reg == gtd_pkg::ST_IDLE);
	endproperty
	a_fund_len: assert property (p_fund_len) else $error("Eight tone pass length wrong.");

	property p_harm_len;
		@(posedge clk) disable iff (srst)
			accept && harmonic_select |-> ##32 (state_reg == gtd_pkg::ST_WR)
			&& (freq_reg == `GTD_FREQ_LAST_HARM) ##1 (state_reg == gtd_pkg::ST_IDLE);
	endproperty
	a_harm_len: assert property (p_harm_len) else $error("Sixteen tone pass length wrong.");

	property p_first_zero;
		@(posedge clk) disable iff (srst) mem_bus.wr_en && first_s_reg
			|-> (mem_bus.wr_data[15:0] == 16'h0000) && (mem_bus.wr_data[31:16] == x_reg);
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("Block start not from zero.");

	property p_src;
		@(posedge clk) disable iff (srst) accept |-> pcm_dir == tone_source_select;
	endproperty
	a_src: assert property (p_src) else $error("Sample from wrong source taken.");

	property p_host;
		@(posedge clk) disable iff (srst) host_rd |-> ##2 host_rvalid;
	endproperty
	a_host: assert property (p_host) else $error("Host read data late.");

	property p_budget;
		@(posedge clk) disable iff (srst) busy_cnt < `GTD_SAMPLE_CYC;
	endproperty
	a_budget: assert property (p_budget) else $error("Pass exceeds sample period.");

	c_halt: cover property (@(posedge clk) disable iff (srst) halt_now);
	c_restart: cover property (@(posedge clk) disable iff (srst) restart_reg && halted_reg);
	c_harm: cover property (@(posedge clk) disable iff (srst) accept && harmonic_select);
	c_wrap: cover property (@(posedge clk) disable iff (srst)
		running && pcm_frame && (idx_reg == len_reg) && !stop_after_block);
endmodule : gtd_tone_detector
`default_nettype wire

// file: gtd_host_model.sv
// Host side model that fetches coefficient words from the detector memory.
`timescale 1ns/10ps
`default_nettype none
module gtd_host_model (
	input wire logic clk,
	output logic [15:0] host_addr,
	output logic host_rd,
	input wire logic [7:0] host_rdata,
	input wire logic host_rvalid
);
	initial
	begin
		host_addr = 16'h0000;
		host_rd = 1'b0;
	end
	// Four byte reads give Wn then Wn-1, low byte first; a missing answer clears ok.
	task automatic read_entry(input logic [15:0] a, output logic [15:0] wn,
		output logic [15:0] wm, output bit ok);
		logic [7:0] b [4];
		int n;
		ok = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			host_addr <= a + 16'(i);
			host_rd <= 1'b1;
			@(posedge clk);
			host_rd <= 1'b0;
			#1;
			for (n = 0; n < 4 && host_rvalid !== 1'b1; n++)
			begin
				@(posedge clk);
				#1;
			end
			ok &= (host_rvalid === 1'b1);
			b[i] = host_rdata;
		end
		wn = {b[1], b[0]};
		wm = {b[3], b[2]};
	endtask : read_entry
	// Power of one bin from its two final states, with the tone constant scaled by two to 14.
	function automatic longint power(input logic signed [15:0] wn, input logic signed [15:0] wm,
		input int k);
		return longint'(wn) * wn + longint'(wm) * wm - ((longint'(k) * wn * wm) >>> 14);
	endfunction : power
	// Key number from the strongest low tone and the strongest high tone, each 0 to 3.
	function automatic int key_of(input int lo, input int hi);
		return lo * 4 + hi;
	endfunction : key_of
endmodule : gtd_host_model
`default_nettype wire

// file: gtd_tone_detector_test.sv
// Self-checking bench for the tone detector.
`timescale 1ns/10ps
`default_nettype none
module gtd_tone_detector_test;
	logic clk, srst, reg_wr, reg_rd, pcm_valid, pcm_dir, pcm_frame, pcm_ready;
	logic host_rd, host_rvalid, tone_block_done_flag;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, pcm_code, host_rdata;
	logic [4:0] pcm_chan;
	logic [15:0] host_addr;
	int n_fail = 0;
	int total_checks = 0;
	int busy8;
	gtd_tone_detector u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pcm_valid(pcm_valid), .pcm_dir(pcm_dir), .pcm_chan(pcm_chan), .pcm_code(pcm_code),
		.pcm_frame(pcm_frame), .pcm_ready(pcm_ready), .host_addr(host_addr),
		.host_rd(host_rd), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
		.tone_block_done_flag(tone_block_done_flag));
	gtd_host_model u_host (.clk(clk), .host_addr(host_addr), .host_rd(host_rd),
		.host_rdata(host_rdata), .host_rvalid(host_rvalid));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic tally_and_finish;
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", what, e, g);
			n_fail++;
		end
	endtask : chk
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_read
	task automatic frame;
		@(posedge clk);
		pcm_frame <= 1'b1;
		@(posedge clk);
		pcm_frame <= 1'b0;
	endtask : frame
	// Offers one sample, then counts the cycles the engine stays busy.
	task automatic sample(input logic [4:0] ch, input logic [7:0] c, output int busy);
		bit acc;
		acc = 1'b0;
		@(posedge clk);
		pcm_chan <= ch;
		pcm_code <= c;
		pcm_valid <= 1'b1;
		for (int i = 0; i < 20 && !acc; i++)
		begin
			#1;
			acc = (pcm_ready === 1'b1);
			@(posedge clk);
		end
		pcm_valid <= 1'b0;
		chk("sample taken", 16'h0001, 16'(acc));
		busy = 0;
		#1;
		while (pcm_ready !== 1'b1 && busy < 100)
		begin
			busy++;
			@(posedge clk);
			#1;
		end
	endtask : sample
	// Companded code to the scaled linear value that the filter consumes.
	function automatic logic signed [15:0] x_of(input logic [7:0] c);
		logic [7:0] u;
		int t;
		u = ~c;
		t = (int'(u[3:0]) * 8 + 132) << u[6:4];
		x_of = 16'((u[7] ? 132 - t : t - 132) >>> 3);
	endfunction : x_of
	// Two-sample block: Wn-1 is the first sample, Wn is K times it.
	task automatic run_block(input logic [7:0] cfg, input logic [4:0] ch, input logic [7:0] c,
		output int busy);
		int b2;
		reg_write(8'h1C, 8'h00);
		reg_write(8'h1D, 8'h01);
		reg_write(8'h1C, cfg);
		frame();
		sample(ch, c, busy);
		frame();
		sample(ch, 8'hFF, b2);
		frame();
		repeat (8) @(posedge clk);
	endtask : run_block
	task automatic chk_coef(input logic [4:0] ch, input int tone, input bit hb, input int k,
		input logic [7:0] c);
		logic [15:0] wn, wm, a;
		logic signed [15:0] x;
		bit ok;
		longint d2;
		x = x_of(c);
		a = 16'h1000 + 16'(tone * 128) + 16'((ch[4] | hb) * 64) + {11'h000, ch[3:0], 2'b00};
		u_host.read_entry(a, wn, wm, ok);
		chk("host answer", 16'h0001, 16'(ok));
		chk("state Wn", 16'((int'(x) * k) >>> 14), wn);
		chk("state Wn-1", x, wm);
		// With Wn equal to K times Wn-1 the power reduces to the square of the sample.
		d2 = u_host.power($signed(wn), $signed(wm), k) - longint'(x) * x;
		chk("power", 16'h0001, 16'(d2 < 16384 && d2 > -16384));
	endtask : chk_coef
	initial
	begin
		logic [7:0] d;
		logic [7:0] ra [4] = '{8'h1C, 8'h1D, 8'h1E, 8'h55};
		int b;
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		pcm_valid = 1'b0;
		pcm_dir = 1'b0;
		pcm_frame = 1'b0;
		pcm_chan = 5'h00;
		pcm_code = 8'hFF;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			reg_read(ra[i], d);
			chk("reset read", 16'h0000, {8'h00, d});
		end
		frame();
		#1;
		chk("ready disabled", 16'h0000, {15'h0, pcm_ready});
		run_block(8'h81, 5'd17, 8'h80, busy8);
		chk("fundamental pass", 16'h0010, 16'(busy8));
		#1;
		chk("continuous ready", 16'h0001, {15'h0, pcm_ready});
		chk("continuous flag", 16'h0000, {15'h0, tone_block_done_flag});
		chk_coef(5'd17, 4, 1'b0, 19073, 8'h80);
		chk_coef(5'd17, 5, 1'b0, 16325, 8'h80);
		chk_coef(5'd17, 7, 1'b0, 9315, 8'h80);
		run_block(8'h89, 5'd17, 8'hA0, b);
		chk("done flag", 16'h0001, {15'h0, tone_block_done_flag});
		frame();
		repeat (2) @(posedge clk);
		#1;
		chk("ready halted", 16'h0000, {15'h0, pcm_ready});
		reg_read(8'h1E, d);
		chk("status halted", 16'h0003, {14'h0, d[1:0]});
		reg_read(8'h1E, d);
		chk("status cleared", 16'h0000, {15'h0, d[0]});
		chk("flag cleared", 16'h0000, {15'h0, tone_block_done_flag});
		chk_coef(5'd17, 4, 1'b0, 19073, 8'hA0);
		reg_write(8'h1C, 8'hC9);
		frame();
		sample(5'd17, 8'h80, b);
		frame();
		sample(5'd17, 8'hFF, b);
		frame();
		repeat (8) @(posedge clk);
		chk("restart done", 16'h0001, {15'h0, tone_block_done_flag});
		chk_coef(5'd17, 4, 1'b0, 19073, 8'h80);
		run_block(8'h8B, 5'd5, 8'h80, b);
		chk("harmonic pass", 16'(busy8 + 16), 16'(b));
		chk_coef(5'd5, 0, 1'b1, 14739, 8'h80);
		chk_coef(5'd5, 1, 1'b1, 11221, 8'h80);
		chk_coef(5'd5, 4, 1'b1, -10565, 8'h80);
		chk_coef(5'd5, 7, 1'b1, -27472, 8'h80);
		chk_coef(5'd5, 0, 1'b0, 27980, 8'h80);
		chk("key", 16'h000F, 16'(u_host.key_of(3, 3)));
		reg_read(8'h1E, d);
		reg_write(8'h1C, 8'h00);
		reg_write(8'h1D, 8'h66);
		reg_write(8'h1C, 8'h89);
		repeat (103) frame();
		repeat (2) @(posedge clk);
		#1;
		chk("long block open", 16'h0000, {15'h0, tone_block_done_flag});
		frame();
		repeat (2) @(posedge clk);
		#1;
		chk("long block done", 16'h0001, {15'h0, tone_block_done_flag});
		tally_and_finish();
	end
	initial
	begin
		#(50 * 20000);
		n_fail++;
		tally_and_finish();
	end
endmodule : gtd_tone_detector_test
`default_nettype wire
